/* File: pkg/fspc_pkg.sv */
// ============================================================
// shared constants of the frequency-scan pin control block
// ============================================================
package fspc_pkg;

    // ============================================================
    // serial word layout
    // ============================================================
    localparam int FSPC_WORD_W = 16;
    localparam int FSPC_ADDR_W = 4;
    localparam int FSPC_DATA_W = 12;
    localparam logic [3:0] FSPC_BIT_LAST = 4'hf;

    // ============================================================
    // datapath widths
    // ============================================================
    localparam int FSPC_TUNE_W = 24;
    localparam int FSPC_DAC_W = 10;
    localparam logic [9:0] FSPC_DAC_MIDSCALE = 10'h200;

    // ============================================================
    // register addresses carried in the top nibble of a word
    // ============================================================
    localparam logic [3:0] FSPC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FSPC_ADDR_NINCR = 4'h1;
    localparam logic [3:0] FSPC_ADDR_DELTA_LO = 4'h2;
    localparam logic [3:0] FSPC_ADDR_DELTA_HI = 4'h3;
    localparam logic [3:0] FSPC_ADDR_INTERVAL = 4'h4;
    localparam logic [3:0] FSPC_ADDR_START_LO = 4'h5;
    localparam logic [3:0] FSPC_ADDR_START_HI = 4'h6;

    // ============================================================
    // control word fields
    // ============================================================
    localparam int FSPC_CTRL_AUTO_BIT = 0;
    localparam int FSPC_CTRL_SRC_BIT = 1;
    localparam int FSPC_CTRL_STAT_EN_BIT = 2;
    localparam int FSPC_CTRL_WAVE_EN_BIT = 3;

    // ============================================================
    // reset values
    // ============================================================
    localparam logic [11:0] FSPC_CTRL_RESET = 12'h000;
    localparam logic [11:0] FSPC_PARAM_RESET = 12'h000;

    typedef enum logic [1:0] {
        FSPC_IDLE,
        FSPC_RUN,
        FSPC_DONE
    } fspc_state_t;

endpackage

/* File: sim/fspc_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// host end of the serial link; its clock rests high between frames
// ============================================================
module fspc_host_model (
    output logic sclk_link,
    output logic frame_sync_n,
    output logic serial_in_line
);
    initial begin
        sclk_link = 1'b1;
        frame_sync_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // n bits in one low frame, top bit first; 32 bits is two words
    task automatic send(input logic [31:0] v, input int n);
        #7.3;
        frame_sync_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = v[i];
            #20 sclk_link = 1'b0;
            #40 sclk_link = 1'b1;
            #20;
        end
        frame_sync_n = 1'b1;
        // a released line flips so a stale bit never passes for data
        serial_in_line = ~serial_in_line;
    endtask
endmodule // fspc_host_model

/* File: sim/fspc_top_assertions.sv */
`timescale 1ns/1ps
// ============================================================
// pin checks of the scan control block
// ============================================================
module fspc_top_assertions
    import fspc_pkg::*;
#(
    parameter int DAC_W = FSPC_DAC_W
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scan_trigger,
    input wire logic scan_abort,
    input wire logic standby,
    input wire logic scan_status_output,
    input wire logic digital_wave_output,
    input wire logic digital_wave_output_oe_n,
    input wire logic [DAC_W-1:0] analog_wave_output,
    input wire logic scan_finished,
    input wire logic scan_running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_idle;
        !scan_running && !scan_finished;
    endsequence
    sequence s_trig_rise;
        $rose(scan_trigger) && !standby;
    endsequence
    chk_reset_state: assert property (
        $fell(srst) |-> !scan_status_output && !digital_wave_output && digital_wave_output_oe_n
            && !scan_running && !scan_finished && analog_wave_output == FSPC_DAC_MIDSCALE
    ) else $error("outputs not at rest after reset");
    chk_wave_inverse: assert property (
        !digital_wave_output_oe_n && !$past(digital_wave_output_oe_n)
            && $stable(analog_wave_output) |-> digital_wave_output == !analog_wave_output[DAC_W-1]
    ) else $error("digital wave is not the inverted dac top bit");
    chk_wave_quiet: assert property (
        digital_wave_output_oe_n |-> !digital_wave_output
    ) else $error("digital wave active while disabled");
    chk_state_excl: assert property (
        !(scan_running && scan_finished)
    ) else $error("running and finished together");
    chk_idle_midscale: assert property (
        s_idle [*3] |-> analog_wave_output == FSPC_DAC_MIDSCALE
    ) else $error("idle dac not at midscale");
    chk_abort_stops: assert property (
        $rose(scan_abort) && !standby |-> ##[1:6] s_idle
    ) else $error("abort did not stop the scan");
    chk_trig_starts: assert property (
        s_trig_rise ##0 s_idle |-> ##[3:7] scan_running
    ) else $error("trigger did not start the scan");
    chk_run_cause: assert property (
        $rose(scan_running) |-> $past(scan_trigger, 4)
    ) else $error("scan started too soon after trigger");
    chk_status_cause: assert property (
        scan_status_output |-> scan_running || scan_finished || $past(scan_running)
    ) else $error("status output with no scan");
    chk_standby_hold: assert property (
        standby [*6] |-> $stable(analog_wave_output) && $stable(scan_running)
    ) else $error("scan moved during standby");
endmodule // fspc_top_assertions

bind fspc_top fspc_top_assertions #(.DAC_W(DAC_W)) fspc_top_assertions_inst (
    .clk_sys(clk_sys), .srst(srst), .scan_trigger(scan_trigger),
    .scan_abort(scan_abort), .standby(standby),
    .scan_status_output(scan_status_output), .digital_wave_output(digital_wave_output),
    .digital_wave_output_oe_n(digital_wave_output_oe_n),
    .analog_wave_output(analog_wave_output), .scan_finished(scan_finished),
    .scan_running(scan_running)
);

/* File: sim/fspc_top_tb.sv */
`timescale 1ns/1ps
// ============================================================
// scenario bench of the scan control block
// ============================================================
module fspc_top_tb;
    import fspc_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b0;
    logic scan_trigger = 1'b0;
    logic scan_abort = 1'b0;
    logic standby = 1'b0;
    logic sclk_link, frame_sync_n, serial_in_line;
    logic scan_status_output, digital_wave_output, digital_wave_output_oe_n;
    logic scan_finished, scan_running;
    logic [FSPC_DAC_W-1:0] analog_wave_output;
    int err_total = 0;
    int check_count = 0;
    int pulse_cnt = 0;
    int cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    fspc_host_model fspc_host_model_inst (.sclk_link(sclk_link),
        .frame_sync_n(frame_sync_n), .serial_in_line(serial_in_line));
    fspc_top fspc_top_inst (.clk_sys(clk_sys), .srst(srst), .sclk_link(sclk_link),
        .frame_sync_n(frame_sync_n), .serial_in_line(serial_in_line),
        .scan_trigger(scan_trigger), .scan_abort(scan_abort), .standby(standby),
        .scan_status_output(scan_status_output), .digital_wave_output(digital_wave_output),
        .digital_wave_output_oe_n(digital_wave_output_oe_n),
        .analog_wave_output(analog_wave_output), .scan_finished(scan_finished),
        .scan_running(scan_running));
    // step pulses last one cycle, so count them at every edge
    always @(posedge clk_sys) begin
        if (scan_status_output === 1'b1) pulse_cnt++;
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // held 8 cycles: well over the one-cycle minimum width
    task automatic trig();
        @(negedge clk_sys);
        scan_trigger = 1'b1;
        clks(8);
        scan_trigger = 1'b0;
        clks(4);
    endtask
    task automatic wait_flag(input bit fin, input int lim);
        int n;
        n = 0;
        while ((fin ? scan_finished : scan_running) !== 1'b1 && n < lim) begin
            clks(1);
            n++;
        end
        check(fin ? "finish wait" : "run wait", 1, n < lim);
    endtask
    // start 0x100000, delta 0x040000; control word goes first
    task automatic setup(input logic [11:0] ctrl, input logic [11:0] ninc, input logic [11:0] ivl);
        fspc_host_model_inst.send({FSPC_ADDR_CTRL, ctrl, FSPC_ADDR_NINCR, ninc}, 32);
        fspc_host_model_inst.send({FSPC_ADDR_DELTA_LO, 12'h000, FSPC_ADDR_DELTA_HI, 12'h040}, 32);
        fspc_host_model_inst.send({FSPC_ADDR_INTERVAL, ivl, FSPC_ADDR_START_LO, 12'h000}, 32);
        fspc_host_model_inst.send({16'h0000, FSPC_ADDR_START_HI, 12'h100}, 16);
        clks(10);
        pulse_cnt = 0;
    endtask
    task automatic t_reset();
        check("status", 0, scan_status_output);
        check("wave oe_n", 1, digital_wave_output_oe_n);
        check("wave", 0, digital_wave_output);
        check("dac", FSPC_DAC_MIDSCALE, analog_wave_output);
        $display("test reset done");
    endtask
    task automatic t_auto_step();
        logic [FSPC_DAC_W-1:0] a;
        setup(12'h00f, 12'h002, 12'h003);
        trig();
        wait_flag(1, 100);
        check("step pulses", 2, pulse_cnt);
        check("wave oe_n", 0, digital_wave_output_oe_n);
        a = analog_wave_output;
        clks(1);
        check("dac moving", 1, analog_wave_output !== a);
        check("dac step", 10'(a + 10'h060), analog_wave_output);
        clks(40);
        check("final hold", 1, scan_finished);
        trig();
        check("done ignores trig", 2, pulse_cnt);
        $display("test auto step done");
    endtask
    task automatic t_modes();
        setup(12'h00d, 12'h002, 12'h003);
        trig();
        wait_flag(1, 100);
        clks(3);
        check("end status", 1, scan_status_output);
        setup(12'h001, 12'h002, 12'h003);
        trig();
        wait_flag(1, 100);
        clks(3);
        check("quiet pulses", 0, pulse_cnt);
        check("quiet oe_n", 1, digital_wave_output_oe_n);
        check("quiet wave", 0, digital_wave_output);
        $display("test modes done");
    endtask
    task automatic t_ext();
        setup(12'h006, 12'h002, 12'h003);
        trig();
        wait_flag(0, 20);
        for (int i = 1; i <= 2; i++) begin
            trig();
            check("ext step", i, pulse_cnt);
            check("ext running", 1, scan_running);
        end
        trig();
        check("ext end", 1, scan_finished);
        $display("test external done");
    endtask
    // mode 0: abort pin, 1: control write, 2: standby
    task automatic t_stop(input int mode);
        logic [FSPC_DAC_W-1:0] a;
        setup(12'h009, 12'h002, 12'hfff);
        trig();
        wait_flag(0, 20);
        clks(20);
        if (mode == 2) begin
            standby = 1'b1;
            clks(8);
            a = analog_wave_output;
            clks(20);
            check("standby dac", a, analog_wave_output);
            check("standby run", 1, scan_running);
            standby = 1'b0;
            clks(8);
            check("wake dac", 1, analog_wave_output !== a);
            fspc_host_model_inst.send({16'h0000, FSPC_ADDR_CTRL, 12'h009}, 16);
            clks(8);
            standby = 1'b1;
            clks(20);
            check("reset standby dac", FSPC_DAC_MIDSCALE, analog_wave_output);
            check("reset standby run", 0, scan_running);
            standby = 1'b0;
            clks(4);
        end else begin
            if (mode == 0) scan_abort = 1'b1;
            else fspc_host_model_inst.send({16'h0000, FSPC_ADDR_CTRL, 12'h009}, 16);
            clks(8);
            check("stop run", 0, scan_running);
            check("stop dac", FSPC_DAC_MIDSCALE, analog_wave_output);
            scan_abort = 1'b0;
            clks(4);
        end
        $display("test stop %0d done", mode);
    endtask
    initial begin
        // a real rising edge, so the link-side async clears see it
        #1;
        srst = 1'b1;
        clks(2);
        srst = 1'b0;
        clks(2);
        t_reset();
        t_auto_step();
        t_modes();
        t_ext();
        for (int m = 0; m < 3; m++) t_stop(m);
        wrap_up();
    end
endmodule // fspc_top_tb

/* File: src/fspc_serial_rx.sv */
`timescale 1ns/1ps
// ============================================================
// serial word receiver, runs on the falling edge of the link clock
// ============================================================
module fspc_serial_rx
    import fspc_pkg::*;
#(
    parameter int WORD_W = FSPC_WORD_W
) (
    input wire logic srst,
    input wire logic sclk_link,
    input wire logic frame_sync_n,
    input wire logic serial_in_line,
    output logic [WORD_W-1:0] word_hold,
    output logic word_toggle
);

    logic [3:0] bit_cnt_r;
    logic [WORD_W-2:0] shift_r;
    logic word_done;

    assign word_done = (bit_cnt_r == FSPC_BIT_LAST);

    // ============================================================
    // bit counter
    // ============================================================
    // the link clock may stop between frames, so the idle frame sync
    // itself clears the count rather than a later clock edge; reset clears
    // it too, since frame sync may never have risen since power-up
    always_ff @(negedge sclk_link or posedge frame_sync_n or posedge srst) begin
        if (frame_sync_n || srst) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // ============================================================
    // shift register and word hold
    // ============================================================
    always_ff @(negedge sclk_link) begin
        if (!frame_sync_n) begin
            shift_r <= {shift_r[WORD_W-3:0], serial_in_line};
        end
    end

    // hold stays put for sixteen link clocks, far longer than the crossing
    always_ff @(negedge sclk_link) begin
        if (!frame_sync_n && word_done) begin
            word_hold <= {shift_r, serial_in_line};
        end
    end

    always_ff @(negedge sclk_link or posedge srst) begin
        if (srst) begin
            word_toggle <= 1'b0;
        end else if (!frame_sync_n && word_done) begin
            word_toggle <= ~word_toggle;
        end
    end

endmodule // fspc_serial_rx

/* File: src/fspc_top.sv */
`timescale 1ns/1ps
module fspc_top
    import fspc_pkg::*;
#(
    parameter int TUNE_W = FSPC_TUNE_W,
    parameter int DAC_W = FSPC_DAC_W
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sclk_link,
    input wire logic frame_sync_n,
    input wire logic serial_in_line,
    input wire logic scan_trigger,
    input wire logic scan_abort,
    input wire logic standby,
    output logic scan_status_output,
    output logic digital_wave_output,
    output logic digital_wave_output_oe_n,
    output logic [DAC_W-1:0] analog_wave_output,
    output logic scan_finished,
    output logic scan_running
);
    import fspc_pkg::*;

    // ============================================================
    // helpers
    // ============================================================
    function automatic logic rose(input logic now_v, input logic was_v);
        rose = now_v & ~was_v;
    endfunction

    function automatic logic [TUNE_W-1:0] join_half(
        input logic [TUNE_W-1:0] old_v,
        input logic [FSPC_DATA_W-1:0] part_v,
        input logic upper_v
    );
        logic [TUNE_W-1:0] res_v;
        res_v = old_v;
        if (upper_v) begin
            res_v[TUNE_W-1:TUNE_W-FSPC_DATA_W] = part_v;
        end else begin
            res_v[FSPC_DATA_W-1:0] = part_v;
        end
        join_half = res_v;
    endfunction

    // ============================================================
    // serial link receiver
    // ============================================================
    logic [FSPC_WORD_W-1:0] word_hold;
    logic word_toggle;

    // words cross by a toggle; the held word stays put long after the flip
    fspc_serial_rx #(
        .WORD_W(FSPC_WORD_W)
    ) fspc_serial_rx_inst (
        .srst(srst),
        .sclk_link(sclk_link),
        .frame_sync_n(frame_sync_n),
        .serial_in_line(serial_in_line),
        .word_hold(word_hold),
        .word_toggle(word_toggle)
    );

    // ============================================================
    // synchronisers for pins and the word toggle
    // ============================================================
    logic trig_meta_r, trig_sync_r, trig_prev_r;
    logic abort_meta_r, abort_sync_r, abort_prev_r;
    logic stby_meta_r, stby_sync_r;
    logic tog_meta_r, tog_sync_r, tog_prev_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trig_meta_r <= 1'b0;
            trig_sync_r <= 1'b0;
            abort_meta_r <= 1'b0;
            abort_sync_r <= 1'b0;
            stby_meta_r <= 1'b0;
            stby_sync_r <= 1'b0;
            tog_meta_r <= 1'b0;
            tog_sync_r <= 1'b0;
        end else begin
            trig_meta_r <= scan_trigger;
            trig_sync_r <= trig_meta_r;
            abort_meta_r <= scan_abort;
            abort_sync_r <= abort_meta_r;
            stby_meta_r <= standby;
            stby_sync_r <= stby_meta_r;
            tog_meta_r <= word_toggle;
            tog_sync_r <= tog_meta_r;
        end
    end

    // ============================================================
    // standby hold and edge detection
    // ============================================================
    // the clock itself is never gated: a gated clock would glitch and
    // the synchronisers must keep running to see standby fall again
    logic run_ok;
    assign run_ok = ~stby_sync_r;

    // edge history freezes in standby, so an edge that arrives meanwhile
    // takes effect on wake-up if the pin is still high or a single word came; a pulse over by then is lost
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trig_prev_r <= 1'b0;
            abort_prev_r <= 1'b0;
            tog_prev_r <= 1'b0;
        end else if (run_ok) begin
            trig_prev_r <= trig_sync_r;
            abort_prev_r <= abort_sync_r;
            tog_prev_r <= tog_sync_r;
        end
    end

    // a pin pulse shorter than one system clock may slip past the synchroniser
    logic trig_rise, abort_rise, word_new;
    assign trig_rise = run_ok & rose(trig_sync_r, trig_prev_r);
    assign abort_rise = run_ok & rose(abort_sync_r, abort_prev_r);
    assign word_new = run_ok & (tog_sync_r ^ tog_prev_r);

    // ============================================================
    // register writes
    // ============================================================
    logic [FSPC_ADDR_W-1:0] word_addr;
    logic [FSPC_DATA_W-1:0] word_data;
    assign word_addr = word_hold[FSPC_WORD_W-1:FSPC_DATA_W];
    assign word_data = word_hold[FSPC_DATA_W-1:0];

    logic ctrl_wr, scan_reset;
    assign ctrl_wr = word_new & (word_addr == FSPC_ADDR_CTRL);
    assign scan_reset = ctrl_wr | abort_rise;

    logic [FSPC_DATA_W-1:0] ctrl_r;
    logic [FSPC_DATA_W-1:0] nincr_r;
    logic [FSPC_DATA_W-1:0] interval_r;
    logic [TUNE_W-1:0] delta_r;
    logic [TUNE_W-1:0] start_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_r <= FSPC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= word_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nincr_r <= FSPC_PARAM_RESET;
            interval_r <= FSPC_PARAM_RESET;
            delta_r <= '0;
            start_r <= '0;
        end else if (word_new) begin
            case (word_addr)
                FSPC_ADDR_NINCR: begin
                    nincr_r <= word_data;
                end
                FSPC_ADDR_INTERVAL: begin
                    interval_r <= word_data;
                end
                FSPC_ADDR_DELTA_LO: begin
                    delta_r <= join_half(delta_r, word_data, 1'b0);
                end
                FSPC_ADDR_DELTA_HI: begin
                    delta_r <= join_half(delta_r, word_data, 1'b1);
                end
                FSPC_ADDR_START_LO: begin
                    start_r <= join_half(start_r, word_data, 1'b0);
                end
                FSPC_ADDR_START_HI: begin
                    start_r <= join_half(start_r, word_data, 1'b1);
                end
                default: begin
                end
            endcase
        end
    end

    logic mode_auto, src_step, stat_en, wave_en;
    assign mode_auto = ctrl_r[FSPC_CTRL_AUTO_BIT];
    assign src_step = ctrl_r[FSPC_CTRL_SRC_BIT];
    assign stat_en = ctrl_r[FSPC_CTRL_STAT_EN_BIT];
    assign wave_en = ctrl_r[FSPC_CTRL_WAVE_EN_BIT];

    // ============================================================
    // scan sequencer
    // ============================================================
    fspc_state_t state_r;
    logic [FSPC_DATA_W-1:0] step_cnt_r;
    logic [FSPC_DATA_W-1:0] ivl_cnt_r;
    logic [TUNE_W-1:0] freq_r;
    logic step_pulse_r;

    logic step_now, last_step;
    assign step_now = (state_r == FSPC_RUN) & run_ok &
        (mode_auto ? (ivl_cnt_r == interval_r) : trig_rise);
    assign last_step = (step_cnt_r == nincr_r);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= FSPC_IDLE;
        end else if (scan_reset) begin
            state_r <= FSPC_IDLE;
        end else if (run_ok) begin
            case (state_r)
                FSPC_IDLE: begin
                    if (trig_rise) begin
                        state_r <= FSPC_RUN;
                    end
                end
                FSPC_RUN: begin
                    if (step_now && last_step) begin
                        state_r <= FSPC_DONE;
                    end
                end
                FSPC_DONE: begin
                    state_r <= FSPC_DONE;
                end
                default: begin
                    state_r <= FSPC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || scan_reset) begin
            step_cnt_r <= '0;
            freq_r <= '0;
            step_pulse_r <= 1'b0;
        end else if (run_ok) begin
            step_pulse_r <= 1'b0;
            if (state_r == FSPC_IDLE && trig_rise) begin
                step_cnt_r <= '0;
                freq_r <= start_r;
            end else if (step_now && !last_step) begin
                step_cnt_r <= step_cnt_r + 12'h001;
                freq_r <= freq_r + delta_r;
                step_pulse_r <= 1'b1;
            end
        end
    end

    // a dwell lasts interval_r + 1 cycles; external mode leaves it idle
    always_ff @(posedge clk_sys) begin
        if (srst || scan_reset) begin
            ivl_cnt_r <= '0;
        end else if (run_ok) begin
            if (state_r != FSPC_RUN || step_now) begin
                ivl_cnt_r <= '0;
            end else if (mode_auto) begin
                ivl_cnt_r <= ivl_cnt_r + 12'h001;
            end
        end
    end

    // ============================================================
    // phase accumulator and dac code
    // ============================================================
    logic [TUNE_W-1:0] phase_r;
    logic [DAC_W-1:0] dac_r;
    logic wave_bit_r;

    always_ff @(posedge clk_sys) begin
        if (srst || scan_reset) begin
            phase_r <= '0;
        end else if (run_ok) begin
            if (state_r == FSPC_IDLE) begin
                phase_r <= '0;
            end else begin
                phase_r <= phase_r + freq_r;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || scan_reset) begin
            dac_r <= FSPC_DAC_MIDSCALE;
            wave_bit_r <= ~FSPC_DAC_MIDSCALE[DAC_W-1];
        end else if (run_ok) begin
            if (state_r == FSPC_IDLE) begin
                dac_r <= FSPC_DAC_MIDSCALE;
                wave_bit_r <= ~FSPC_DAC_MIDSCALE[DAC_W-1];
            end else begin
                dac_r <= phase_r[TUNE_W-1:TUNE_W-DAC_W];
                wave_bit_r <= ~phase_r[TUNE_W-1];
            end
        end
    end

    // ============================================================
    // pin outputs
    // ============================================================
    logic stat_r, wave_r, wave_oe_n_r, done_r, run_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stat_r <= 1'b0;
            wave_r <= 1'b0;
            wave_oe_n_r <= 1'b1;
            done_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            stat_r <= stat_en &
                (src_step ? step_pulse_r : (state_r == FSPC_DONE));
            wave_r <= wave_en & wave_bit_r;
            wave_oe_n_r <= ~wave_en;
            done_r <= (state_r == FSPC_DONE);
            run_r <= (state_r == FSPC_RUN);
        end
    end

    assign scan_status_output = stat_r;
    assign digital_wave_output = wave_r;
    assign digital_wave_output_oe_n = wave_oe_n_r;
    assign analog_wave_output = dac_r;
    assign scan_finished = done_r;
    assign scan_running = run_r;

endmodule // fspc_top
